// ### src/mjs_consts.vh
// constants for the memory reference and jump phase sequencer
`ifndef MJS_CONSTS_VH
`define MJS_CONSTS_VH

// machine timing
`define MJS_CLK_KHZ       10000
`define MJS_PHASE_NS      2000
`define MJS_PHASE_CYC     ((`MJS_PHASE_NS * `MJS_CLK_KHZ) / 1000000)
`define MJS_NUM_TP        16'h0008
`define MJS_CYC_MID_T2    ((5 * `MJS_PHASE_CYC) / 16)
`define MJS_CYC_LATE_T2   (`MJS_CYC_MID_T2 + 1)

// time period numbers
`define MJS_TP0           3'h0
`define MJS_TP1           3'h1
`define MJS_TP2           3'h2
`define MJS_TP5           3'h5
`define MJS_TP6           3'h6
`define MJS_TP7           3'h7

// instruction word fields
`define MJS_OPC_LSB       10
`define MJS_OPC_MSB       15
`define MJS_ADDR_MSB      9
`define MJS_IND_BIT       15
`define MJS_JUMP_CODE     4'h5

// function selections
`define MJS_FN_NONE       3'h0
`define MJS_FN_ADD        3'h1
`define MJS_FN_PASS_S     3'h7

// register byte offsets
`define MJS_REG_CTRL      8'h00
`define MJS_REG_STATUS    8'h04
`define MJS_REG_PC        8'h08
`define MJS_REG_MAR       8'h0C
`define MJS_REG_HOLDER    8'h10

// field positions
`define MJS_CTRL_RUN      0
`define MJS_ST_FETCH      0
`define MJS_ST_IND        1
`define MJS_ST_EXEC       2
`define MJS_ST_TP_LSB     4
`define MJS_ST_OPC_LSB    8

// reset values
`define MJS_RST_CTRL      32'h0000_0000
`define MJS_RST_WORD      16'h0000
`define MJS_RST_OPC       6'h00
`define MJS_RST_RUN       1'b0

`endif

// ### src/mjs_sequencer.v
// fetch, indirect and jump phase sequencer with an ahb-lite register port
//
// Notes on behaviour
// RL1: clear memory word holder in fetch T0
// RL2: memory read ors into holder until mid T2
// RL3: clear opcode register in fetch T1
// RL4: mid T2 copies holder bits 10-15 to opcode
// RL5: late T2 sets read, store, function selects
// RL6: holder bits 0-9 are in-page operand address
// RL7: page-zero jump clears whole pc in T5
// RL8: page zero clears mar bits 10-15 in T6/T7
// RL9: current page keeps upper pc and mar bits
// RL10: T6/T7 test holder bit 15 for indirect
// RL11: direct jump loads bits 0-9 to pc, mar
// RL12: direct jump keeps fetch flag set
// RL13: indirect jump loads mar only, pc untouched; a page-zero indirect jump still has pc cleared in T5
// RL14: indirect jump sets indirect flag at T7
// RL15: indirect phase clears holder, keeps opcode
// RL16: unconditional branch never enters execute phase
// RL17: non-jump fetch and indirect actions are common
// RL18: eight periods repeat every 2.0 us
// RL19: indirect jump retests bit 15, loops or finishes
// RL20: non-jump fetch loads mar, picks next phase
//
// The AHB-Lite interface to the registers and the register offsets were decided locally.
`include "mjs_consts.vh"

module mjs_sequencer #(
  parameter PHASE_CYC = `MJS_PHASE_CYC
) (
  // clock, reset, enable
  input  wire        clk_sys,
  input  wire        rst_b,
  input  wire        clk_en,
  // ahb-lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  // core memory
  output reg  [15:0] mem_addr,
  output reg         mem_rd,
  output reg         mem_wr,
  output reg  [15:0] mem_wdata,
  input  wire [15:0] mem_rdata,
  // sequencer state
  output reg  [15:0] program_counter,
  output reg  [5:0]  opcode_register,
  output reg  [2:0]  time_period,
  output reg         fetch_phase_flag,
  output reg         indirect_phase_flag,
  output reg         execute_phase_flag,
  output reg         sel_read,
  output reg         sel_store,
  output reg  [2:0]  sel_func
);

  // phase length at the width the period arithmetic uses
  localparam [15:0] PHASE_LEN = PHASE_CYC[15:0];

  // time period of a cycle within the phase
  function [2:0] tp_of;
    input [7:0] cyc;
    reg   [15:0] prod;
    reg   [15:0] quot;
    begin
      prod  = {8'h00, cyc} * `MJS_NUM_TP;
      quot  = prod / PHASE_LEN;
      tp_of = quot[2:0];
    end
  endfunction

  reg  [7:0]  cyc_cnt;
  reg  [15:0] memory_word_holder;
  reg  [15:0] mar;
  reg         run;
  reg         bus_wr_pend;
  reg  [7:0]  bus_addr;
  wire [7:0]  next_cyc;
  wire        is_jump;
  wire        is_memref;
  wire        page_zero;
  wire        ind_bit;
  wire        at_t0;
  wire        at_t1;
  wire        at_t5;
  wire        at_t6;
  wire        at_end;
  wire        in_read;
  wire [15:0] pc_inc;
  wire [15:0] ind_word;
  wire [31:0] status_word;
  wire        bus_take;

  assign next_cyc  = (cyc_cnt == PHASE_CYC - 1) ? 8'h00 : cyc_cnt + 8'h01;
  assign is_jump   = (opcode_register[4:1] == `MJS_JUMP_CODE);
  assign is_memref = (opcode_register[4:1] != 4'h0);
  assign page_zero = ~opcode_register[0];
  assign ind_bit   = memory_word_holder[`MJS_IND_BIT];
  assign at_t0     = (cyc_cnt == 8'h00);
  assign at_t1     = (tp_of(cyc_cnt) == `MJS_TP1) && (tp_of(cyc_cnt - 8'h01) == `MJS_TP0);
  assign at_t5     = (tp_of(cyc_cnt) == `MJS_TP5) && (tp_of(cyc_cnt - 8'h01) != `MJS_TP5);
  assign at_t6     = (tp_of(cyc_cnt) == `MJS_TP6) && (tp_of(cyc_cnt - 8'h01) != `MJS_TP6);
  assign at_end    = (cyc_cnt == PHASE_CYC - 1);
  assign in_read   = (cyc_cnt <= `MJS_CYC_MID_T2);
  assign pc_inc    = program_counter + 16'h0001;
  assign ind_word  = {1'b0, memory_word_holder[14:0]};
  assign bus_take  = hsel && hready && htrans[1];
  assign status_word = {16'h0000, 2'b00, opcode_register, 1'b0, time_period,
                        1'b0, execute_phase_flag, indirect_phase_flag, fetch_phase_flag};

  // ahb-lite slave: registered zero-wait answers, always okay
  always @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      hrdata      <= 32'h0000_0000;
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
      bus_wr_pend <= 1'b0;
      bus_addr    <= 8'h00;
    end
    else if (clk_en)
    begin
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
      bus_wr_pend <= bus_take && hwrite;
      if (bus_take)
        bus_addr <= haddr[7:0];
      if (bus_take && !hwrite)
      begin
        case (haddr[7:0])
          `MJS_REG_CTRL:   hrdata <= {31'h0000_0000, run};
          `MJS_REG_STATUS: hrdata <= status_word;
          `MJS_REG_PC:     hrdata <= {16'h0000, program_counter};
          `MJS_REG_MAR:    hrdata <= {16'h0000, mar};
          `MJS_REG_HOLDER: hrdata <= {16'h0000, memory_word_holder};
          default:         hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // run control bit
  always @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      run <= `MJS_RST_RUN;
    else if (clk_en && bus_wr_pend && bus_addr == `MJS_REG_CTRL)
      run <= hwdata[`MJS_CTRL_RUN];
  end

  // machine cycle counter, eight periods per phase
  always @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cyc_cnt     <= 8'h00;
      time_period <= `MJS_TP0;
    end
    else if (clk_en && run)
    begin
      cyc_cnt     <= next_cyc;        // RL18
      time_period <= tp_of(next_cyc); // RL18
    end
  end

  // memory cycle: read half then restoring write half
  always @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      mem_rd    <= 1'b0;
      mem_wr    <= 1'b0;
      mem_addr  <= `MJS_RST_WORD;
      mem_wdata <= `MJS_RST_WORD;
    end
    else if (clk_en)
    begin
      mem_rd    <= run && (next_cyc != 8'h00) && (next_cyc <= `MJS_CYC_MID_T2); // RL2
      mem_wr    <= run && (next_cyc > `MJS_CYC_MID_T2) && (tp_of(next_cyc) < `MJS_TP6);
      mem_addr  <= mar;
      mem_wdata <= memory_word_holder;
    end
  end

  // memory word holder: cleared in T0, loaded by the read
  always @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      memory_word_holder <= `MJS_RST_WORD;
    else if (clk_en && run)
    begin
      if (at_t0)
        memory_word_holder <= `MJS_RST_WORD;                     // RL1 RL15
      else if (mem_rd && in_read)
        memory_word_holder <= memory_word_holder | mem_rdata;    // RL2
    end
  end

  // opcode register: cleared in T1 and loaded mid T2 in fetch only
  always @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      opcode_register <= `MJS_RST_OPC;
    else if (clk_en && run && fetch_phase_flag)
    begin
      if (at_t1)
        opcode_register <= `MJS_RST_OPC;                         // RL3 RL15
      else if (cyc_cnt == `MJS_CYC_MID_T2)
        opcode_register <= memory_word_holder[`MJS_OPC_MSB:`MJS_OPC_LSB]; // RL4
    end
  end

  // function selections set up late in T2
  always @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sel_read  <= 1'b0;
      sel_store <= 1'b0;
      sel_func  <= `MJS_FN_NONE;
    end
    else if (clk_en && run && fetch_phase_flag && cyc_cnt == `MJS_CYC_LATE_T2)
    begin
      sel_read  <= is_memref;                                    // RL5
      sel_store <= is_memref;                                    // RL5
      sel_func  <= is_jump ? `MJS_FN_NONE :
                   (is_memref ? `MJS_FN_ADD : `MJS_FN_PASS_S);   // RL5
    end
  end

  // program counter, address register and phase flags
  always @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      program_counter     <= `MJS_RST_WORD;
      mar                 <= `MJS_RST_WORD;
      fetch_phase_flag    <= 1'b1;
      indirect_phase_flag <= 1'b0;
      execute_phase_flag  <= 1'b0;
    end
    else if (clk_en && !run && bus_wr_pend)
    begin
      if (bus_addr == `MJS_REG_PC)
        program_counter <= hwdata[15:0];
      if (bus_addr == `MJS_REG_MAR)
        mar <= hwdata[15:0];
    end
    else if (clk_en && run && fetch_phase_flag)
    begin
      if (at_t5 && is_jump && page_zero)
        program_counter <= `MJS_RST_WORD;                        // RL7
      if (at_t6 && is_memref && page_zero)
        mar[`MJS_OPC_MSB:`MJS_OPC_LSB] <= `MJS_RST_OPC;          // RL8 RL9
      if (at_end && is_jump && !ind_bit)                         // RL10 RL12
      begin
        program_counter[`MJS_ADDR_MSB:0] <= memory_word_holder[`MJS_ADDR_MSB:0]; // RL11 RL6
        mar[`MJS_ADDR_MSB:0]             <= memory_word_holder[`MJS_ADDR_MSB:0]; // RL11 RL9
      end
      else if (at_end && is_memref)
      begin
        mar[`MJS_ADDR_MSB:0] <= memory_word_holder[`MJS_ADDR_MSB:0]; // RL13 RL20 RL6
        fetch_phase_flag     <= 1'b0;
        indirect_phase_flag  <= ind_bit;                         // RL14 RL17
        execute_phase_flag   <= !ind_bit;                        // RL20 RL16
      end
      else if (at_end)
      begin
        program_counter <= pc_inc;
        mar             <= pc_inc;
      end
    end
    else if (clk_en && run && indirect_phase_flag && at_end)
    begin
      mar <= ind_word;                                           // RL19 RL17
      if (!ind_bit && is_jump)
      begin
        program_counter     <= ind_word;                         // RL19
        fetch_phase_flag    <= 1'b1;                             // RL19 RL16
        indirect_phase_flag <= 1'b0;
      end
      else if (!ind_bit)
      begin
        execute_phase_flag  <= 1'b1;                             // RL17
        indirect_phase_flag <= 1'b0;
      end
    end
    else if (clk_en && run && execute_phase_flag && at_end)
    begin
      program_counter    <= pc_inc;
      mar                <= pc_inc;
      fetch_phase_flag   <= 1'b1;
      execute_phase_flag <= 1'b0;
    end
  end

endmodule // mjs_sequencer

// ### dv/mjs_seq_assertions.sv
// timing and phase checks on the sequencer ports
module mjs_seq_assertions (
  // clock and reset
  input logic        clk_sys,
  input logic        rst_b,
  // sequencer state
  input logic [15:0] program_counter,
  input logic [5:0]  opcode_register,
  input logic [2:0]  time_period,
  input logic        fetch_phase_flag,
  input logic        indirect_phase_flag,
  input logic        execute_phase_flag,
  // core memory
  input logic        mem_rd,
  input logic        mem_wr,
  input logic [15:0] mem_wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // fetch phase of a jump just ended at this edge
  sequence s_jend;
    time_period == 3'h0 && $past(time_period) == 3'h7 && $past(fetch_phase_flag)
      && $past(opcode_register[4:1]) == 4'h5;
  endsequence
  chk_rd_window:
    assert property (mem_rd |-> time_period <= 3'h2 && !mem_wr) else $error("read late");
  chk_opc_clear:
    assert property (fetch_phase_flag && time_period == 3'h2 && $past(time_period) == 3'h1
      |-> opcode_register == 6'h00) else $error("opcode not cleared");
  chk_opc_load:
    assert property (fetch_phase_flag && time_period == 3'h3
      |-> opcode_register == mem_wdata[15:10]) else $error("opcode not loaded");
  chk_opc_hold:
    assert property (indirect_phase_flag && $past(indirect_phase_flag)
      |-> $stable(opcode_register)) else $error("opcode lost");
  chk_no_exec:
    assert property (execute_phase_flag |-> opcode_register[4:1] != 4'h5)
      else $error("branch in execute");
  chk_jump_direct:
    assert property (s_jend ##0 !$past(opcode_register[5]) |-> fetch_phase_flag
      && program_counter[9:0] == $past(mem_wdata[9:0])) else $error("bad target");
  chk_jump_page:
    assert property (s_jend ##0 !$past(opcode_register[5]) |-> program_counter[15:10]
      == ($past(opcode_register[0]) ? $past(program_counter[15:10]) : 6'h00))
      else $error("bad page");
  chk_jump_ind:
    assert property (s_jend ##0 $past(opcode_register[5]) |-> indirect_phase_flag
      && $stable(program_counter)) else $error("bad indirect");
  // main paths reached
  cover property ($rose(indirect_phase_flag));
  cover property ($rose(execute_phase_flag));
  cover property (indirect_phase_flag ##1 fetch_phase_flag);
endmodule // mjs_seq_assertions

// ### dv/mjs_mem_model.sv
// core memory model behind the memory word holder
module mjs_mem_model (
  // clock
  input  logic        clk_sys,
  // memory port
  input  logic [15:0] mem_addr,
  input  logic        mem_rd,
  input  logic        mem_wr,
  input  logic [15:0] mem_wdata,
  output logic [15:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] cells [0:65535];
  logic [15:0] last_word = 16'h0000;
  // blank core so every fetch sees a defined word
  initial
  begin
    foreach (cells[i])
      cells[i] = 16'h0000;
  end
  // outside the read half the lines show the complement of the last word read
  assign mem_rdata = mem_rd ? cells[mem_addr] : ~last_word;
  // write half restores the word
  always @(posedge clk_sys)
  begin
    if (mem_rd)
      last_word <= cells[mem_addr];
    if (mem_wr)
      cells[mem_addr] <= mem_wdata;
  end
endmodule // mjs_mem_model

// ### dv/mjs_sequencer_tb.sv
// testbench for the jump phase sequencer
module mjs_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys, rst_b, clk_en, hsel, hwrite, hreadyout, hresp, mem_rd, mem_wr;
  logic        fetch_phase_flag, indirect_phase_flag, execute_phase_flag, sel_read, sel_store;
  logic [31:0] haddr, hwdata, hrdata;
  logic [15:0] mem_addr, mem_wdata, mem_rdata, program_counter;
  logic [5:0]  opcode_register;
  logic [2:0]  hsize, time_period, sel_func;
  logic [1:0]  htrans;
  int          bad_count, checked;
  // design and its core memory
  mjs_sequencer #(.PHASE_CYC(20)) mjs_sequencer_i (
    .clk_sys, .rst_b, .clk_en, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .mem_addr, .mem_rd, .mem_wr,
    .mem_wdata, .mem_rdata, .program_counter, .opcode_register, .time_period,
    .fetch_phase_flag, .indirect_phase_flag, .execute_phase_flag, .sel_read,
    .sel_store, .sel_func);
  mjs_mem_model mjs_mem_model_i (.clk_sys, .mem_addr, .mem_rd, .mem_wr, .mem_wdata,
    .mem_rdata);
  // 10 MHz clock
  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one single word transfer, entered just after a rising edge
  task automatic bus(input logic wr, input logic [31:0] a, wd, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  // run n phases, then freeze early in the next one
  task automatic run_case(input logic [15:0] pc0, w0, w1, input int n,
      input logic [15:0] epc, emar, input logic [2:0] efl, input logic [5:0] eopc,
      input logic [4:0] esel);
    logic [31:0] rd;
    rst_b <= 1'b0;
    clk_en <= 1'b1;
    @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    mjs_mem_model_i.cells[pc0] = w0;
    mjs_mem_model_i.cells[{pc0[15:10], w0[9:0]}] = w1;
    bus(1'b1, 32'h08, 32'(pc0), rd);
    bus(1'b1, 32'h0C, 32'(pc0), rd);
    bus(1'b1, 32'h00, 32'h1, rd);
    repeat (n)
    begin
      while (time_period !== 3'h7) @(posedge clk_sys);
      while (time_period !== 3'h0) @(posedge clk_sys);
    end
    clk_en <= 1'b0;
    @(posedge clk_sys);
    cmp("pc", 32'(epc), 32'(program_counter));
    cmp("mar", 32'(emar), 32'(mem_addr));
    cmp("flags", 32'(efl), 32'({execute_phase_flag, indirect_phase_flag, fetch_phase_flag}));
    cmp("opcode", 32'(eopc), 32'(opcode_register));
    cmp("selects", 32'(esel), 32'({sel_read, sel_store, sel_func}));
  endtask
  // reset values, read-only and unmapped places
  task automatic test_regs();
    logic [31:0] rd;
    bus(1'b1, 32'h04, 32'hFF, rd);
    bus(1'b0, 32'h04, 32'h0, rd);
    cmp("status", 32'h1, rd);
    bus(1'b1, 32'h40, 32'h5, rd);
    bus(1'b0, 32'h40, 32'h0, rd);
    cmp("unmapped", 32'h0, rd);
    cmp("hresp", 32'h0, 32'(hresp));
  endtask
  // direct jumps to current page and page zero, plain instruction
  task automatic test_direct();
    run_case(16'h1400, 16'h2D23, 16'h0, 1,
      16'h1523, 16'h1523, 3'h1, 6'h0B, 5'h18);
    run_case(16'h1400, 16'h2923, 16'h0, 1,
      16'h0123, 16'h0123, 3'h1, 6'h0A, 5'h18);
    run_case(16'h1400, 16'h0000, 16'h0, 1,
      16'h1401, 16'h1401, 3'h1, 6'h00, 5'h07);
  endtask
  // indirect jump: one level, finished, chained
  task automatic test_indirect();
    run_case(16'h1400, 16'hAC10, 16'h0, 1,
      16'h1400, 16'h1410, 3'h2, 6'h2B, 5'h18);
    run_case(16'h1400, 16'hAC10, 16'h0456, 2,
      16'h0456, 16'h0456, 3'h1, 6'h2B, 5'h18);
    run_case(16'h1400, 16'hAC10, 16'h8456, 2,
      16'h1400, 16'h0456, 3'h2, 6'h2B, 5'h18);
  endtask
  // other memory reference words, direct and indirect
  task automatic test_memref();
    run_case(16'h1400, 16'h0C20, 16'h0, 1,
      16'h1400, 16'h1420, 3'h4, 6'h03, 5'h19);
    run_case(16'h1400, 16'h8C20, 16'h0077, 2,
      16'h1400, 16'h0077, 3'h4, 6'h23, 5'h19);
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // watchdog against a hung wait
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    bad_count++;
    report_and_stop();
  end
  // main sequence
  initial
  begin
    {rst_b, hsel, hwrite, haddr, hwdata, htrans} = '0;
    clk_en = 1'b1;
    hsize = 3'h2;
    repeat (20) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    test_regs();
    test_direct();
    test_indirect();
    test_memref();
    report_and_stop();
  end
endmodule // mjs_sequencer_tb
bind mjs_sequencer mjs_seq_assertions mjs_seq_assertions_i (.clk_sys, .rst_b,
  .program_counter, .opcode_register, .time_period, .fetch_phase_flag,
  .indirect_phase_flag, .execute_phase_flag, .mem_rd, .mem_wr, .mem_wdata);
